// *** src/lec_top.sv ***
/*
 * lane error counter control: paged per-lane hold, enable and clear settings,
 * counter readout, terminal-count interrupt, all behind an ahb-lite slave.
 * assumes a single master doing single word transfers, error pulses synchronous.
 */
//
// Contract
// - Hold, enable and clear bits map bit 2 to unexpected control characters, bit 1 to invalid code groups, bit 0 to disparity.
// - With its hold bit set, a counter stops at 0xFF and stays there until cleared.
// - With its hold bit clear, a counter wraps from 0xFF to zero.
// - Hold setting accesses go to the link chosen by the link page register at 0x300.
// - Lane 4 hold sits in bits 2:0 of 0x48C, resets to 0x7, and bits 7:3 read zero.
// - Each lane has per-counter enable bits 5:3 and clear bits 2:0 in the same bit order.
`timescale 1ns/1ps
`default_nettype none
module lec_top (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic [31:0] hrdata_out,
  output logic hreadyout_out,
  output logic hresp_out,
  input wire lec_pkg::lec_lane_vec_t unexpected_control_char_err_in,
  input wire lec_pkg::lec_lane_vec_t invalid_code_group_err_in,
  input wire lec_pkg::lec_lane_vec_t running_disparity_err_in,
  output logic lane_decoder_block_soft_reset_out,
  output logic irq_out
);
  import lec_pkg::*;

  // ****************************************************************
  // decode helpers
  // ****************************************************************
  function automatic logic lane_hit(input lec_idx_t idx, input lec_idx_t base);
    lane_hit = (idx >= base) && (idx < base + lec_idx_t'(NUM_LANES));
  endfunction

  function automatic int lane_sel(input logic page, input lec_idx_t idx, input lec_idx_t base);
    lec_idx_t off;
    off = idx - base;
    lane_sel = int'(page) * NUM_LANES + int'(off[2:0]);
  endfunction

  // ****************************************************************
  // state
  // ****************************************************************
  logic page_reg;
  logic srst_reg;
  logic [2:0] hold_reg [LANES_TOTAL];
  logic [2:0] ena_reg [LANES_TOTAL];
  logic [2:0] clr_reg [LANES_TOTAL];
  lec_lane_vec_t status_reg;
  lec_lane_vec_t mask_reg;
  lec_lane_vec_t status_set;
  lec_count_t cnt_w [LANES_TOTAL][3];
  logic wr_pend_reg;
  logic rd_pend_reg;
  lec_idx_t wr_idx_reg;
  lec_idx_t rd_idx_reg;
  logic hready_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_next;
  logic irq_reg;
  logic addr_ok;
  logic rd_status;

  // ****************************************************************
  // lane counter groups
  // ****************************************************************
  lec_cnt_if lane_if [LANES_TOTAL] ();

  genvar g;
  generate
    for (g = 0; g < LANES_TOTAL; g++) begin : g_lane
      assign lane_if[g].hold = hold_reg[g];
      assign lane_if[g].ena = ena_reg[g];
      assign lane_if[g].clr = clr_reg[g];
      assign lane_if[g].err = {unexpected_control_char_err_in[g], invalid_code_group_err_in[g],
                               running_disparity_err_in[g]};
      assign cnt_w[g][0] = lane_if[g].cnt[0];
      assign cnt_w[g][1] = lane_if[g].cnt[1];
      assign cnt_w[g][2] = lane_if[g].cnt[2];
      assign status_set[g] = |lane_if[g].tc_evt;
      lec_lane_counters u_cnt (
        .mclk_in(mclk_in),
        .nrst_in(nrst_in),
        .bus(lane_if[g])
      );
    end
  endgenerate

  // ****************************************************************
  // ahb-lite address phase
  // ****************************************************************
  // reads take one wait state so hrdata leaves a flip-flop and a write in
  // its data phase is always visible to the read that follows
  assign addr_ok = hsel_in && htrans_in[1] && hready_in;

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      wr_idx_reg <= '0;
      rd_idx_reg <= '0;
      hready_reg <= 1'b1;
    end else begin
      wr_pend_reg <= addr_ok && hwrite_in;
      rd_pend_reg <= addr_ok && !hwrite_in;
      if (addr_ok && hwrite_in) begin
        wr_idx_reg <= haddr_in[IDX_W+1:2];
      end
      if (addr_ok && !hwrite_in) begin
        rd_idx_reg <= haddr_in[IDX_W+1:2];
      end
      hready_reg <= !(addr_ok && !hwrite_in);
    end
  end

  // ****************************************************************
  // register writes
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      page_reg <= 1'b0;
      srst_reg <= 1'b0;
    end else if (wr_pend_reg) begin
      if (wr_idx_reg == IDX_LINK_PAGE) begin
        page_reg <= hwdata_in[PAGE_BIT];
      end
      if (wr_idx_reg == IDX_DEC_SRST) begin
        srst_reg <= hwdata_in[DEC_SRST_BIT];
      end
    end
  end

  // hold settings are not locked against use outside soft reset; software
  // keeps that discipline
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < LANES_TOTAL; i++) begin
        hold_reg[i] <= HOLD_RST;
      end
    end else if (wr_pend_reg && lane_hit(wr_idx_reg, IDX_HOLD_BASE)) begin
      hold_reg[lane_sel(page_reg, wr_idx_reg, IDX_HOLD_BASE)] <= hwdata_in[2:0];
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < LANES_TOTAL; i++) begin
        ena_reg[i] <= ENA_RST;
        clr_reg[i] <= CLR_RST;
      end
    end else if (wr_pend_reg && lane_hit(wr_idx_reg, IDX_CTRL_BASE)) begin
      ena_reg[lane_sel(page_reg, wr_idx_reg, IDX_CTRL_BASE)] <= hwdata_in[ENA_LSB+2:ENA_LSB];
      clr_reg[lane_sel(page_reg, wr_idx_reg, IDX_CTRL_BASE)] <= hwdata_in[CLR_LSB+2:CLR_LSB];
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      mask_reg <= MASK_RST;
    end else if (wr_pend_reg && wr_idx_reg == IDX_MASK) begin
      mask_reg <= hwdata_in[LANES_TOTAL-1:0];
    end
  end

  // ****************************************************************
  // read mux
  // ****************************************************************
  always_comb begin
    lec_idx_t off;
    int ln;
    off = rd_idx_reg - IDX_CNT_BASE;
    ln = int'(page_reg) * NUM_LANES + int'(off[4:2]);
    rd_next = 32'h0000_0000;
    if (rd_idx_reg == IDX_LINK_PAGE) begin
      rd_next[PAGE_BIT] = page_reg;
    end else if (rd_idx_reg == IDX_DEC_SRST) begin
      rd_next[DEC_SRST_BIT] = srst_reg;
    end else if (lane_hit(rd_idx_reg, IDX_CTRL_BASE)) begin
      rd_next[5:0] = {ena_reg[lane_sel(page_reg, rd_idx_reg, IDX_CTRL_BASE)],
                      clr_reg[lane_sel(page_reg, rd_idx_reg, IDX_CTRL_BASE)]};
    end else if (lane_hit(rd_idx_reg, IDX_HOLD_BASE)) begin
      // upper bits stay zero as reserved
      rd_next[2:0] = hold_reg[lane_sel(page_reg, rd_idx_reg, IDX_HOLD_BASE)];
    end else if (rd_idx_reg >= IDX_CNT_BASE && rd_idx_reg <= IDX_CNT_LAST && off[1:0] != 2'h3) begin
      rd_next[CNT_W-1:0] = cnt_w[ln][off[1:0]];
    end else if (rd_idx_reg == IDX_STATUS) begin
      rd_next[LANES_TOTAL-1:0] = status_reg;
    end else if (rd_idx_reg == IDX_MASK) begin
      rd_next[LANES_TOTAL-1:0] = mask_reg;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      hrdata_reg <= 32'h0000_0000;
    end else if (rd_pend_reg) begin
      hrdata_reg <= rd_next;
    end
  end

  // ****************************************************************
  // terminal count interrupt
  // ****************************************************************
  assign rd_status = rd_pend_reg && (rd_idx_reg == IDX_STATUS);

  // a terminal count in the cycle of the clearing read is kept
  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      status_reg <= '0;
    end else if (rd_status) begin
      status_reg <= status_set;
    end else begin
      status_reg <= status_reg | status_set;
    end
  end

  always_ff @(posedge mclk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(status_reg & mask_reg);
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign hrdata_out = hrdata_reg;
  assign hreadyout_out = hready_reg;
  assign hresp_out = 1'b0;
  assign lane_decoder_block_soft_reset_out = srst_reg;
  assign irq_out = irq_reg;

endmodule
`default_nettype wire

// *** src/lec_pkg.sv ***
/*
 * shared constants for the lane error counter block: register indices,
 * field positions, reset values and lane geometry.
 * assumes registers sit on one aligned 32-bit word each, byte address = index * 4.
 */
package lec_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int NUM_LINKS = 2;
  localparam int NUM_LANES = 8;
  localparam int LANES_TOTAL = NUM_LINKS * NUM_LANES;
  localparam int CNT_W = 8;
  localparam int IDX_W = 12;

  typedef logic [LANES_TOTAL-1:0] lec_lane_vec_t;
  typedef logic [CNT_W-1:0] lec_count_t;
  typedef logic [IDX_W-1:0] lec_idx_t;

  // ****************************************************************
  // register indices
  // ****************************************************************
  localparam lec_idx_t IDX_LINK_PAGE = 12'h300;
  localparam lec_idx_t IDX_DEC_SRST = 12'h475;
  localparam lec_idx_t IDX_CTRL_BASE = 12'h480;
  localparam lec_idx_t IDX_HOLD_BASE = 12'h488;
  localparam lec_idx_t IDX_LANE4_HOLD = 12'h48C;
  localparam lec_idx_t IDX_CNT_BASE = 12'h490;
  localparam lec_idx_t IDX_CNT_LAST = 12'h4AF;
  localparam lec_idx_t IDX_STATUS = 12'h4B0;
  localparam lec_idx_t IDX_MASK = 12'h4B1;

  // ****************************************************************
  // field positions and reset values
  // ****************************************************************
  localparam int BIT_UNEXP = 2;
  localparam int BIT_INVALID = 1;
  localparam int BIT_DISP = 0;
  localparam int ENA_LSB = 3;
  localparam int CLR_LSB = 0;
  localparam int DEC_SRST_BIT = 3;
  localparam int PAGE_BIT = 0;
  localparam logic [2:0] HOLD_RST = 3'h7;
  localparam logic [2:0] ENA_RST = 3'h7;
  localparam logic [2:0] CLR_RST = 3'h7;
  localparam lec_count_t CNT_TERMINAL = 8'hFF;
  localparam lec_lane_vec_t MASK_RST = 16'h0000;

endpackage

// *** src/lec_cnt_if.sv ***
/*
 * carrier between the top and one lane's counter group.
 * assumes a single clock domain shared by both ends.
 */
`timescale 1ns/1ps
`default_nettype none
interface lec_cnt_if;
  import lec_pkg::*;
  logic [2:0] hold;
  logic [2:0] ena;
  logic [2:0] clr;
  logic [2:0] err;
  lec_count_t cnt [3];
  logic [2:0] tc_evt;

  modport ctl_mp(output hold, output ena, output clr, output err, input cnt, input tc_evt);
  modport cnt_mp(input hold, input ena, input clr, input err, output cnt, output tc_evt);
endinterface
`default_nettype wire

// *** src/lec_lane_counters.sv ***
/*
 * the three error counters of one lane with hold or wrap at terminal count.
 * assumes error inputs are one-cycle pulses synchronous to mclk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module lec_lane_counters (
  input wire logic mclk_in,
  input wire logic nrst_in,
  lec_cnt_if.cnt_mp bus
);
  import lec_pkg::*;

  // ****************************************************************
  // counters, one per error type, bit order shared with hold bits
  // ****************************************************************
  genvar c;
  generate
    for (c = 0; c < 3; c++) begin : g_cnt
      lec_count_t count_reg;
      logic tc_reg;
      always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
          count_reg <= '0;
          tc_reg <= 1'b0;
        end else if (bus.clr[c]) begin
          // clear bit held high keeps the counter at zero
          count_reg <= '0;
          tc_reg <= 1'b0;
        end else if (bus.ena[c] && bus.err[c]) begin
          if (count_reg == CNT_TERMINAL) begin
            if (bus.hold[c]) begin
              count_reg <= count_reg;
            end else begin
              count_reg <= '0;
            end
            tc_reg <= 1'b0;
          end else begin
            count_reg <= count_reg + 8'h01;
            tc_reg <= (count_reg == CNT_TERMINAL - 8'h01);
          end
        end else begin
          tc_reg <= 1'b0;
        end
      end
      assign bus.cnt[c] = count_reg;
      assign bus.tc_evt[c] = tc_reg;
    end
  endgenerate
endmodule
`default_nettype wire

// *** bench/lec_top_props.sv ***
/* assertions on the ports of lec_top.
   assumes hready_in is fed from hreadyout_out. */
`timescale 1ns/1ps
`default_nettype none
module lec_top_props (
  input wire logic mclk_in,
  input wire logic nrst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  input wire logic [31:0] hrdata_out,
  input wire logic hreadyout_out,
  input wire logic hresp_out,
  input wire lec_pkg::lec_lane_vec_t unexpected_control_char_err_in,
  input wire lec_pkg::lec_lane_vec_t invalid_code_group_err_in,
  input wire lec_pkg::lec_lane_vec_t running_disparity_err_in,
  input wire logic lane_decoder_block_soft_reset_out,
  input wire logic irq_out
);
  import lec_pkg::*;
  // ****
  // bus, soft reset and irq timing
  // ****
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!nrst_in);
  logic acc, rda, srw, mkw, wd3, err;
  lec_idx_t idx;
  assign idx = haddr_in[13:2];
  assign acc = hsel_in && htrans_in[1] && hready_in;
  assign rda = acc && !hwrite_in;
  assign srw = acc && hwrite_in && idx == IDX_DEC_SRST;
  assign mkw = acc && hwrite_in && idx == IDX_MASK;
  assign wd3 = hwdata_in[DEC_SRST_BIT];
  assign err = |{unexpected_control_char_err_in, invalid_code_group_err_in, running_disparity_err_in};
  property p_rd_wait; rda |=> !hreadyout_out ##1 hreadyout_out; endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait");
  property p_wr_go; acc && hwrite_in |=> hreadyout_out; endproperty
  a_wr_go: assert property (p_wr_go) else $error("write wait");
  property p_hold_rsv; rda && idx == IDX_LANE4_HOLD |=> ##1 hrdata_out[31:3] == 29'h0; endproperty
  a_hold_rsv: assert property (p_hold_rsv) else $error("hold upper bits");
  property p_cnt_rsv;
    rda && idx >= IDX_CNT_BASE && idx <= IDX_CNT_LAST |=> ##1 hrdata_out[31:8] == 24'h0;
  endproperty
  a_cnt_rsv: assert property (p_cnt_rsv) else $error("count upper bits");
  property p_sr_set; srw |=> ##1 lane_decoder_block_soft_reset_out == $past(wd3); endproperty
  a_sr_set: assert property (p_sr_set) else $error("soft reset value");
  property p_sr_why; $changed(lane_decoder_block_soft_reset_out) |-> $past(srw, 2); endproperty
  a_sr_why: assert property (p_sr_why) else $error("soft reset moved");
  property p_irq_rst; $rose(nrst_in) |-> !irq_out ##1 !irq_out; endproperty
  a_irq_rst: assert property (p_irq_rst) else $error("irq after reset");
  property p_irq_why;
    $rose(irq_out) |-> $past(err, 3) || $past(err, 4) || $past(mkw, 2) || $past(mkw, 3);
  endproperty
  a_irq_why: assert property (p_irq_why) else $error("irq without cause");
endmodule
bind lec_top lec_top_props u_props (
  .mclk_in(mclk_in),
  .nrst_in(nrst_in),
  .hsel_in(hsel_in),
  .haddr_in(haddr_in),
  .htrans_in(htrans_in),
  .hwrite_in(hwrite_in),
  .hsize_in(hsize_in),
  .hwdata_in(hwdata_in),
  .hready_in(hready_in),
  .hrdata_out(hrdata_out),
  .hreadyout_out(hreadyout_out),
  .hresp_out(hresp_out),
  .unexpected_control_char_err_in(unexpected_control_char_err_in),
  .invalid_code_group_err_in(invalid_code_group_err_in),
  .running_disparity_err_in(running_disparity_err_in),
  .lane_decoder_block_soft_reset_out(lane_decoder_block_soft_reset_out),
  .irq_out(irq_out)
);
`default_nettype wire

// *** bench/lec_link_tx.sv ***
/* link transmitter model: one error pulse per bad character.
   assumes pulses are sampled on rising mclk_in. */
`timescale 1ns/1ps
`default_nettype none
module lec_link_tx (
  input wire logic mclk_in,
  output var lec_pkg::lec_lane_vec_t err_out [3]
);
  import lec_pkg::*;
  initial begin
    err_out = '{default: '0};
  end
  // kind 0 unexpected, 1 invalid, 2 disparity; one character a cycle
  task automatic send(input int kind, input int lane, input int n);
    repeat (n) begin
      @(posedge mclk_in);
      err_out[kind] <= 16'h0001 << lane;
    end
    @(posedge mclk_in);
    err_out[kind] <= '0;
  endtask
endmodule
`default_nettype wire

// *** bench/tb_lec_top.sv ***
/* bench for lec_top: registers, paging, counters, irq.
   assumes lec_link_tx drives the error pulses. */
`timescale 1ns/1ps
`default_nettype none
module tb_lec_top;
  import lec_pkg::*;
  localparam lec_idx_t H4 = IDX_LANE4_HOLD;
  localparam lec_idx_t C4 = IDX_CTRL_BASE + 12'h004;
  localparam lec_idx_t K4 = IDX_CNT_BASE + 12'h010;
  logic mclk_in, nrst_in, hsel_in, hwrite_in, hreadyout_out, hresp_out, irq_out;
  logic lane_decoder_block_soft_reset_out;
  logic [1:0] htrans_in;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, rd;
  lec_lane_vec_t errs [3];
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  lec_top dut (
    .mclk_in(mclk_in),
    .nrst_in(nrst_in),
    .hsel_in(hsel_in),
    .haddr_in(haddr_in),
    .htrans_in(htrans_in),
    .hwrite_in(hwrite_in),
    .hsize_in(3'h2),
    .hwdata_in(hwdata_in),
    .hready_in(hreadyout_out),
    .hrdata_out(hrdata_out),
    .hreadyout_out(hreadyout_out),
    .hresp_out(hresp_out),
    .unexpected_control_char_err_in(errs[0]),
    .invalid_code_group_err_in(errs[1]),
    .running_disparity_err_in(errs[2]),
    .lane_decoder_block_soft_reset_out(lane_decoder_block_soft_reset_out),
    .irq_out(irq_out)
  );
  lec_link_tx tx (.mclk_in(mclk_in), .err_out(errs));
  // ****
  // helpers
  // ****
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %h not %h", $time, got, exp);
    end
  endtask
  // the answer is awaited, never assumed
  task automatic bus(input lec_idx_t idx, input logic wr, input logic [31:0] wd);
    @(posedge mclk_in);
    hsel_in <= 1'b1;
    htrans_in <= 2'h2;
    hwrite_in <= wr;
    haddr_in <= {18'h0, idx, 2'h0};
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    do @(posedge mclk_in); while (hreadyout_out !== 1'b1);
    rd = hrdata_out;
  endtask
  task automatic rdchk(input lec_idx_t idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0);
    check(rd, exp);
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_regs;
    rdchk(H4, 32'h7);
    bus(IDX_DEC_SRST, 1'b1, 32'h8);
    @(posedge mclk_in);
    check({31'h0, lane_decoder_block_soft_reset_out}, 32'h1);
    rdchk(IDX_DEC_SRST, 32'h8);
    bus(H4, 1'b1, 32'hFFFFFFFF);
    rdchk(H4, 32'h7);
    bus(IDX_LINK_PAGE, 1'b1, 32'h1);
    rdchk(IDX_LINK_PAGE, 32'h1);
    bus(H4, 1'b1, 32'h2);
    rdchk(H4, 32'h2);
    bus(IDX_LINK_PAGE, 1'b1, 32'h0);
    rdchk(H4, 32'h7);
    bus(IDX_DEC_SRST, 1'b1, 32'h0);
    rdchk(12'h4B5, 32'h0);
    check({31'h0, hresp_out}, 32'h0);
    $display("t_regs done");
  endtask
  task automatic t_count;
    bus(C4, 1'b1, 32'h38);
    tx.send(0, 4, 1);
    tx.send(1, 4, 2);
    tx.send(2, 4, 3);
    rdchk(K4 + 12'h2, 32'h1);
    rdchk(K4 + 12'h1, 32'h2);
    rdchk(K4, 32'h3);
    tx.send(2, 4, 253);
    rdchk(K4, 32'hFF);
    check({31'h0, irq_out}, 32'h0);
    rdchk(IDX_STATUS, 32'h10);
    rdchk(IDX_STATUS, 32'h0);
    bus(IDX_DEC_SRST, 1'b1, 32'h8);
    bus(H4, 1'b1, 32'h6);
    bus(IDX_DEC_SRST, 1'b1, 32'h0);
    tx.send(2, 4, 1);
    rdchk(K4, 32'h0);
    $display("t_count done");
  endtask
  task automatic t_irq;
    bus(C4, 1'b1, 32'h30);
    tx.send(2, 4, 5);
    rdchk(K4, 32'h0);
    tx.send(1, 4, 1);
    rdchk(K4 + 12'h1, 32'h3);
    bus(IDX_MASK, 1'b1, 32'h10);
    rdchk(IDX_MASK, 32'h10);
    bus(C4, 1'b1, 32'h38);
    tx.send(2, 4, 255);
    repeat (4) @(posedge mclk_in);
    check({31'h0, irq_out}, 32'h1);
    rdchk(IDX_STATUS, 32'h10);
    repeat (3) @(posedge mclk_in);
    check({31'h0, irq_out}, 32'h0);
    bus(C4, 1'b1, 32'h3F);
    rdchk(C4, 32'h3F);
    rdchk(K4, 32'h0);
    $display("t_irq done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    mclk_in = 1'b0;
    forever #50 mclk_in = ~mclk_in;
  end
  initial begin
    nrst_in = 1'b0;
    hsel_in = 1'b0;
    hwrite_in = 1'b0;
    htrans_in = 2'h0;
    haddr_in = 32'h0;
    hwdata_in = 32'h0;
    repeat (6) @(posedge mclk_in);
    nrst_in <= 1'b1;
    t_regs();
    t_count();
    t_irq();
    stop_test();
  end
  // far above the fewer than one thousand cycles the scenarios need
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end
endmodule
`default_nettype wire
